// ===== src/sbm_pkg.sv
// Shared constants and types for the serial bus byte access master
package sbm_pkg;
  // Configuration space offsets
  localparam logic [7:0] SBM_OFS_PM_DATA = 8'ha7;
  localparam logic [7:0] SBM_OFS_BUFFER = 8'hb0;
  localparam logic [7:0] SBM_OFS_OFFSET = 8'hb1;
  localparam logic [7:0] SBM_OFS_TARGET = 8'hb2;
  localparam logic [7:0] SBM_OFS_CTRL = 8'hb3;
  // Reset values
  localparam logic [7:0] SBM_RST_BYTE = 8'h00;
  localparam logic [7:0] SBM_PM_DATA_VAL = 8'h00;
  // Control/status field positions
  localparam int SBM_CTRL_PROT_BIT = 7;
  localparam int SBM_CTRL_BUSY_BIT = 5;
  localparam int SBM_CTRL_TEST_BIT = 2;
  localparam int SBM_CTRL_ERR_BIT = 1;
  // Timing: one bus bit is four quarters
  localparam int SBM_REF_CLK_KHZ = 10000;
  localparam int SBM_SCL_KHZ = 100;
  localparam int SBM_QUARTER_CYC = SBM_REF_CLK_KHZ / (SBM_SCL_KHZ * 4);
  localparam int SBM_TEST_QUARTER_CYC = 4;
  localparam int SBM_ACK_BIT = 8;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } sbm_cfg_req_t;

  typedef struct packed {
    logic scl_out;
    logic scl_oe_n;
    logic sda_out;
    logic sda_oe_n;
  } sbm_link_out_t;

  typedef enum logic [2:0] {
    IT_START, IT_ADDR_W, IT_ADDR_R, IT_INDEX, IT_DATA, IT_RECV, IT_STOP
  } sbm_item_t;
endpackage

// ===== src/sbm_master.sv
// Serial bus byte access master with its configuration registers
`timescale 1ns/1ns
module sbm_master (
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire logic HOST_RST_N,
  input wire sbm_pkg::sbm_cfg_req_t CFG_REQ,
  output logic [7:0] CFG_RDATA,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output sbm_pkg::sbm_link_out_t LINK_OUT
);
  import sbm_pkg::*;

  logic [7:0] buffer_q, buffer_d;
  logic [7:0] offset_q, offset_d;
  logic [7:0] target_q, target_d;
  logic prot_q, prot_d;
  logic test_q, test_d;
  logic err_q, err_d;
  logic busy_q, busy_d;
  logic abort_q, abort_d;
  logic nack_q, nack_d;
  logic [2:0] step_q, step_d;
  logic [3:0] bit_q, bit_d;
  logic [1:0] quarter_q, quarter_d;
  logic [4:0] tick_q, tick_d;
  logic [7:0] rx_q, rx_d;
  logic [7:0] rdata_q, rdata_d;
  sbm_link_out_t link_q, link_d;
  logic [2:0] scl_sync_q, sda_sync_q;
  logic scl_f_q, sda_f_q;

  sbm_item_t item;
  logic is_byte, scl_rel, sda_rel, stall, tick_last, tx_bit;
  logic [7:0] tx_byte;
  logic [4:0] qlen;

  // Step list of the current request, with an abort forcing the stop
  function automatic sbm_item_t seq_item(input logic [2:0] step, input logic rd,
                                         input logic short_p);
    sbm_item_t it;
    it = IT_STOP;
    unique case (step)
      3'd0: it = IT_START;
      3'd1: it = (short_p && rd) ? IT_ADDR_R : IT_ADDR_W;
      3'd2: it = short_p ? (rd ? IT_RECV : IT_DATA) : IT_INDEX;
      3'd3: it = short_p ? IT_STOP : (rd ? IT_START : IT_DATA);
      3'd4: it = (!short_p && rd) ? IT_ADDR_R : IT_STOP;
      3'd5: it = (!short_p && rd) ? IT_RECV : IT_STOP;
      default: it = IT_STOP;
    endcase
    return it;
  endfunction

  // Line inputs: three stages, value taken once the last two agree
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      scl_sync_q <= 3'b111;
      sda_sync_q <= 3'b111;
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[1:0], SCL_IN};
      sda_sync_q <= {sda_sync_q[1:0], SDA_IN};
      if (scl_sync_q[1] == scl_sync_q[2]) begin
        scl_f_q <= scl_sync_q[2];
      end
      if (sda_sync_q[1] == sda_sync_q[2]) begin
        sda_f_q <= sda_sync_q[2];
      end
    end
  end

  always_comb begin
    item = abort_q ? IT_STOP : seq_item(step_q, target_q[0], prot_q);
    is_byte = (item != IT_START) && (item != IT_STOP);
    unique case (item)
      IT_ADDR_W: tx_byte = prot_q ? target_q : {target_q[7:1], 1'b0};
      IT_ADDR_R: tx_byte = {target_q[7:1], 1'b1};
      IT_INDEX: tx_byte = offset_q;
      IT_DATA: tx_byte = buffer_q;
      default: tx_byte = 8'hff;
    endcase
    // Line left free for the slave's acknowledge, our closing nack and received bits
    if (bit_q == 4'(SBM_ACK_BIT) || item == IT_RECV) begin
      tx_bit = 1'b1;
    end else begin
      tx_bit = tx_byte[3'(4'd7 - bit_q)];
    end
    // Release pattern per quarter for each symbol
    unique case (item)
      IT_START: begin
        scl_rel = (quarter_q == 2'd1) || (quarter_q == 2'd2);
        sda_rel = (quarter_q == 2'd0) || (quarter_q == 2'd1);
      end
      IT_STOP: begin
        scl_rel = (quarter_q != 2'd0);
        sda_rel = (quarter_q == 2'd2) || (quarter_q == 2'd3);
      end
      default: begin
        scl_rel = (quarter_q == 2'd1) || (quarter_q == 2'd2);
        sda_rel = tx_bit;
      end
    endcase
    if (!busy_q) begin
      scl_rel = 1'b1;
      sda_rel = 1'b1;
    end
    qlen = test_q ? 5'(SBM_TEST_QUARTER_CYC) : 5'(SBM_QUARTER_CYC);
    tick_last = (tick_q == qlen - 5'd1);
    // A slave holding the clock low stretches the high quarters
    stall = scl_rel && !scl_f_q;
  end

  always_comb begin
    buffer_d = buffer_q;
    offset_d = offset_q;
    target_d = target_q;
    prot_d = prot_q;
    test_d = test_q;
    err_d = err_q;
    busy_d = busy_q;
    abort_d = abort_q;
    nack_d = nack_q;
    step_d = step_q;
    bit_d = bit_q;
    quarter_d = quarter_q;
    tick_d = tick_q;
    rx_d = rx_q;
    rdata_d = rdata_q;
    link_d.scl_out = 1'b0;
    link_d.sda_out = 1'b0;
    link_d.scl_oe_n = scl_rel;
    link_d.sda_oe_n = sda_rel;

    if (CFG_REQ.wr) begin
      unique case (CFG_REQ.addr)
        SBM_OFS_BUFFER: buffer_d = CFG_REQ.wdata;
        SBM_OFS_OFFSET: offset_d = CFG_REQ.wdata;
        SBM_OFS_TARGET: begin
          // Write while busy is ignored, the field keeps its value
          if (!busy_q) begin
            target_d = CFG_REQ.wdata;
            busy_d = 1'b1;
            abort_d = 1'b0;
            nack_d = 1'b0;
            step_d = 3'd0;
            bit_d = 4'd0;
            quarter_d = 2'd0;
            tick_d = 5'd0;
          end
        end
        SBM_OFS_CTRL: begin
          prot_d = CFG_REQ.wdata[SBM_CTRL_PROT_BIT];
          test_d = CFG_REQ.wdata[SBM_CTRL_TEST_BIT];
          if (CFG_REQ.wdata[SBM_CTRL_ERR_BIT]) begin
            err_d = 1'b0;
          end
        end
        default: ;
      endcase
    end

    if (busy_q && !stall) begin
      if (!tick_last) begin
        tick_d = tick_q + 5'd1;
      end else begin
        tick_d = 5'd0;
        quarter_d = quarter_q + 2'd1;
        // Sample at the end of the clock high time
        if (quarter_q == 2'd2 && is_byte) begin
          if (bit_q == 4'(SBM_ACK_BIT)) begin
            nack_d = (item != IT_RECV) && sda_f_q;
            if ((item != IT_RECV) && sda_f_q) begin
              err_d = 1'b1;
            end
          end else if (item == IT_RECV) begin
            rx_d = {rx_q[6:0], sda_f_q};
          end
        end
        if (quarter_q == 2'd3) begin
          if (is_byte && bit_q != 4'(SBM_ACK_BIT)) begin
            bit_d = bit_q + 4'd1;
          end else begin
            bit_d = 4'd0;
            step_d = step_q + 3'd1;
            if (item == IT_STOP) begin
              busy_d = 1'b0;
              abort_d = 1'b0;
            end else if (nack_q) begin
              abort_d = 1'b1;
            end
            // Received byte, hardware wins over a host write
            if (item == IT_RECV) begin
              buffer_d = rx_q;
            end
          end
        end
      end
    end

    if (CFG_REQ.rd) begin
      unique case (CFG_REQ.addr)
        SBM_OFS_PM_DATA: rdata_d = SBM_PM_DATA_VAL;
        SBM_OFS_BUFFER: rdata_d = buffer_q;
        SBM_OFS_OFFSET: rdata_d = offset_q;
        SBM_OFS_TARGET: rdata_d = target_q;
        SBM_OFS_CTRL: begin
          rdata_d = 8'h00;
          rdata_d[SBM_CTRL_PROT_BIT] = prot_q;
          rdata_d[SBM_CTRL_BUSY_BIT] = busy_q;
          rdata_d[SBM_CTRL_TEST_BIT] = test_q;
          rdata_d[SBM_CTRL_ERR_BIT] = err_q;
        end
        default: rdata_d = 8'h00;
      endcase
    end
    // Host bus reset only clears the read port, never the fields
    if (!HOST_RST_N) begin
      rdata_d = 8'h00;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      buffer_q <= SBM_RST_BYTE;
      offset_q <= SBM_RST_BYTE;
      target_q <= SBM_RST_BYTE;
      prot_q <= 1'b0;
      test_q <= 1'b0;
      err_q <= 1'b0;
      busy_q <= 1'b0;
      abort_q <= 1'b0;
      nack_q <= 1'b0;
      step_q <= 3'd0;
      bit_q <= 4'd0;
      quarter_q <= 2'd0;
      tick_q <= 5'd0;
      rx_q <= 8'h00;
      rdata_q <= 8'h00;
      link_q <= '{scl_out: 1'b0, scl_oe_n: 1'b1, sda_out: 1'b0, sda_oe_n: 1'b1};
    end else begin
      buffer_q <= buffer_d;
      offset_q <= offset_d;
      target_q <= target_d;
      prot_q <= prot_d;
      test_q <= test_d;
      err_q <= err_d;
      busy_q <= busy_d;
      abort_q <= abort_d;
      nack_q <= nack_d;
      step_q <= step_d;
      bit_q <= bit_d;
      quarter_q <= quarter_d;
      tick_q <= tick_d;
      rx_q <= rx_d;
      rdata_q <= rdata_d;
      link_q <= link_d;
    end
  end

  assign CFG_RDATA = rdata_q;
  assign LINK_OUT = link_q;
endmodule // sbm_master

// ===== bench/sbm_eeprom.sv
// Two-wire slave model that answers byte writes and reads
`timescale 1ns/1ns
module sbm_eeprom #(parameter logic [6:0] ADDR = 7'h50) (
  input wire logic scl,
  input wire logic sda,
  input wire logic [31:0] stretch,
  output logic sda_low,
  output logic scl_low
);
  logic [7:0] lg[$];
  logic [7:0] sh = 8'h00;
  logic [7:0] ofs = 8'h00;
  logic ok = 1'b0;
  logic rd = 1'b0;
  int n = 0;
  int st = 4;
  wire [7:0] tx = ofs ^ 8'h5a;
  initial {sda_low, scl_low} = 2'b00;
  always @(negedge sda) if (scl) {n, st} = 64'd0;
  always @(posedge sda) if (scl) st = 4;
  always @(posedge scl) begin
    sh = {sh[6:0], sda};
    n++;
  end
  always @(negedge scl) if (st != 4) begin
    sda_low <= 1'b0;
    if (n == 8 && st != 3) begin
      lg.push_back(sh);
      if (st == 0) {ok, rd} = {sh[7:1] == ADDR, sh[0]};
      if (st == 1) ofs = sh;
      sda_low <= ok;
    end
    if (n == 9) begin
      n = 0;
      st = (st == 0 && ok) ? (rd ? 3 : 1) : (st == 1 || st == 2) ? 2 : 4;
    end
    if (st == 3 && n < 8) sda_low <= ~tx[7 - n];
  end
  // Slow answer: the clock is held low a while after each fall
  always @(negedge scl) if (stretch > 0 && st != 4) begin
    scl_low = 1'b1;
    #(stretch) scl_low = 1'b0;
  end
endmodule // sbm_eeprom

// ===== bench/sbm_master_sva.sv
// Port-level checker for the serial bus byte access master
`timescale 1ns/1ns
module sbm_master_sva (
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire logic HOST_RST_N,
  input wire sbm_pkg::sbm_cfg_req_t CFG_REQ,
  input wire logic [7:0] CFG_RDATA,
  input wire sbm_pkg::sbm_link_out_t LINK_OUT
);
  import sbm_pkg::*;
  int low_d;
  int low_q;
  logic rel;
  assign rel = LINK_OUT.scl_oe_n && LINK_OUT.sda_oe_n;
  default clocking @(posedge REF_CLK);
  endclocking
  default disable iff (!RESET_N);
  always_comb low_d = LINK_OUT.scl_oe_n ? 0 : low_q + 1;
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) low_q <= 0;
    else low_q <= low_d;
  end
  pm_zero_a: assert property (
    CFG_REQ.rd && CFG_REQ.addr == SBM_OFS_PM_DATA |=> CFG_RDATA == SBM_PM_DATA_VAL)
    else $error("pm data not zero");
  offset_echo_a: assert property (
    CFG_REQ.wr && CFG_REQ.addr == SBM_OFS_OFFSET ##2 CFG_REQ.rd
    && CFG_REQ.addr == SBM_OFS_OFFSET && HOST_RST_N |=> CFG_RDATA == $past(CFG_REQ.wdata, 3))
    else $error("offset readback wrong");
  busy_seen_a: assert property (
    CFG_REQ.rd && CFG_REQ.addr == SBM_OFS_CTRL && HOST_RST_N && !rel
    |=> CFG_RDATA[SBM_CTRL_BUSY_BIT]) else $error("busy clear while driving");
  start_soon_a: assert property (
    CFG_REQ.wr && CFG_REQ.addr == SBM_OFS_TARGET && rel |-> ##[2:70] !LINK_OUT.sda_oe_n)
    else $error("no start after request");
  start_hold_a: assert property (
    $fell(LINK_OUT.sda_oe_n) && LINK_OUT.scl_oe_n
    |-> LINK_OUT.scl_oe_n[*3] ##[1:40] !LINK_OUT.scl_oe_n) else $error("bad start");
  stop_idle_a: assert property (
    $rose(LINK_OUT.sda_oe_n) && LINK_OUT.scl_oe_n |-> rel[*8]) else $error("bad stop");
  err_clear_a: assert property (
    CFG_REQ.wr && CFG_REQ.addr == SBM_OFS_CTRL && CFG_REQ.wdata[1] && rel ##2 CFG_REQ.rd
    && CFG_REQ.addr == SBM_OFS_CTRL && HOST_RST_N |=> !CFG_RDATA[SBM_CTRL_ERR_BIT])
    else $error("error flag not cleared");
  low_phase_a: assert property (
    $rose(LINK_OUT.scl_oe_n) |-> low_q >= SBM_TEST_QUARTER_CYC
    && low_q <= 2 * SBM_QUARTER_CYC) else $error("clock low phase off");
endmodule // sbm_master_sva
bind sbm_master sbm_master_sva sbm_master_sva_i (.REF_CLK(REF_CLK), .RESET_N(RESET_N),
  .HOST_RST_N(HOST_RST_N), .CFG_REQ(CFG_REQ), .CFG_RDATA(CFG_RDATA), .LINK_OUT(LINK_OUT));

// ===== bench/sbm_master_test.sv
// Self-checking bench for the serial bus byte access master
`timescale 1ns/1ns
module sbm_master_test;
  import sbm_pkg::*;
  localparam logic [6:0] DEV = 7'h50;
  logic clk = 0;
  logic rst_n = 0;
  logic hrst_n = 1;
  logic scl_low, sda_low;
  logic [7:0] rdv, o, d, rdata;
  logic [7:0] cur = 8'h00;
  logic [31:0] seed = 32'hc3b9;
  logic [31:0] r;
  int num_errors = 0, n_checks = 0, stretch = 0;
  sbm_cfg_req_t req = '0;
  sbm_link_out_t lo;
  // Open drain with pull-up: released lines read high, driven ones show the driven level
  wire scl_w = (lo.scl_oe_n | lo.scl_out) & ~scl_low;
  wire sda_w = (lo.sda_oe_n | lo.sda_out) & ~sda_low;
  sbm_master sbm_master_i (.REF_CLK(clk), .RESET_N(rst_n), .HOST_RST_N(hrst_n),
    .CFG_REQ(req), .CFG_RDATA(rdata), .SCL_IN(scl_w), .SDA_IN(sda_w), .LINK_OUT(lo));
  sbm_eeprom #(.ADDR(DEV)) sbm_eeprom_i (.scl(scl_w), .sda(sda_w), .stretch(stretch),
    .sda_low(sda_low), .scl_low(scl_low));
  initial forever #50 clk = ~clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Bytes the slave should see, in order
  function automatic logic [7:0] want(input logic rw, s, input logic [7:0] ob, db,
                                      input int k);
    logic [7:0] t[3];
    if (s) t = '{{DEV, rw}, db, 8'h00};
    else t = '{{DEV, 1'b0}, ob, rw ? {DEV, 1'b1} : db};
    return t[k];
  endfunction
  task automatic chk(input logic [7:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cfg(input logic w, input logic [7:0] a, wd);
    req <= '{addr: a, wr: w, rd: !w, wdata: wd};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
    rdv = rdata;
  endtask
  task automatic rd(input logic [7:0] a, exp);
    cfg(1'b0, a, 8'h00);
    chk(rdv, exp);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic idle();
    int k;
    // Stale read data from an earlier access must not end the poll early
    rdv = 8'hff;
    for (k = 0; k < 6000 && rdv[SBM_CTRL_BUSY_BIT] !== 1'b0; k++) cfg(1'b0, SBM_OFS_CTRL, 8'h00);
    if (k == 6000) begin
      num_errors++;
      $display("[FAIL] %0t busy stuck", $time);
      final_report();
    end
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int j = 0; j < 8; j++) rd(8'(SBM_OFS_PM_DATA + j + (j > 0 ? 8 : 0)), 8'h00);
    r = rnd();
    cfg(1'b1, SBM_OFS_PM_DATA, r[7:0] | 8'h01);
    rd(SBM_OFS_PM_DATA, 8'h00);
    cfg(1'b1, SBM_OFS_BUFFER, r[15:8] | 8'h80);
    rd(SBM_OFS_BUFFER, r[15:8] | 8'h80);
    // Host bus reset clears only the read port
    hrst_n <= 1'b0;
    @(posedge clk);
    hrst_n <= 1'b1;
    @(posedge clk);
    chk(rdata, 8'h00);
    rd(SBM_OFS_BUFFER, r[15:8] | 8'h80);
    $display("test reset and host reset done");
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      {d, o} = r[15:0];
      // Long enough to hold the clock past the master's own low quarters
      stretch = r[16] ? 6000 : 0;
      cfg(1'b1, SBM_OFS_CTRL, {i[2], 4'h0, i[0], 2'b00});
      cfg(1'b1, SBM_OFS_BUFFER, d);
      cfg(1'b1, SBM_OFS_OFFSET, o);
      rd(SBM_OFS_OFFSET, o);
      sbm_eeprom_i.lg.delete();
      cfg(1'b1, SBM_OFS_TARGET, {DEV, i[1]});
      rd(SBM_OFS_CTRL, {i[2], 2'b01, 2'b00, i[0], 2'b00});
      idle();
      chk(8'(sbm_eeprom_i.lg.size()), i[2] ? (i[1] ? 8'd1 : 8'd2) : 8'd3);
      foreach (sbm_eeprom_i.lg[k]) chk(sbm_eeprom_i.lg[k], want(i[1], i[2], o, d, k));
      rd(SBM_OFS_BUFFER, i[1] ? (i[2] ? cur : o) ^ 8'h5a : d);
      if (!i[1]) cur = i[2] ? d : o;
      else if (!i[2]) cur = o;
      $display("test %0d done", i);
    end
    cfg(1'b1, SBM_OFS_CTRL, 8'h04);
    sbm_eeprom_i.lg.delete();
    cfg(1'b1, SBM_OFS_TARGET, {~DEV, 1'b0});
    idle();
    rd(SBM_OFS_CTRL, 8'h06);
    chk(8'(sbm_eeprom_i.lg.size()), 8'd1);
    cfg(1'b1, SBM_OFS_CTRL, 8'h02);
    rd(SBM_OFS_CTRL, 8'h00);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(SBM_OFS_OFFSET, 8'h00);
    rd(SBM_OFS_TARGET, 8'h00);
    rd(SBM_OFS_BUFFER, 8'h00);
    $display("test nack and reset done");
    final_report();
  end
endmodule // sbm_master_test
